//--- dv/nibble_logic_skip_rotate_unit_bench.sv
// self-checking bench for the nibble execution unit
`timescale 1ns/1ps
module nibble_logic_skip_rotate_unit_bench;
    logic pclk, presetn, req, req_write, done;
    logic psel, penable, pwrite, pready, pslverr, skip_next;
    logic [11:0] req_addr, paddr;
    logic [31:0] req_wdata, pwdata, prdata;
    logic [32:0] result;
    logic [32:0] exp_q[$];
    logic [3:0] mdl[128];
    logic cy, zf, cf, sk;
    logic [2:0] grow_m;
    int errors = 0;
    int n_checks = 0;
    int seed;

    nibble_exec_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .skip_next(skip_next));

    seq_apb_model seq_u (.pclk(pclk), .presetn(presetn), .req(req), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .done(done), .result(result),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr));

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic test_done();
        if (errors == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : test_done

    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        req <= 1'b1;
        req_write <= wr;
        req_addr <= a;
        req_wdata <= d;
        for (i = 0; i < 20 && done !== 1'b1; i++) begin
            @(negedge pclk);
        end
        if (done !== 1'b1) begin
            errors++;
            test_done();
        end
        @(posedge pclk);
        req <= 1'b0;
    endtask : xfer

    task automatic rd(input logic [11:0] a, input logic [32:0] exp);
        exp_q.push_back(exp);
        xfer(1'b0, a, 32'h0000_0000);
    endtask : rd

    function automatic logic [11:0] maddr(input logic [6:0] i);
        return {nibble_unit_pkg::MEM_WINDOW, i, 2'b00};
    endfunction : maddr

    task automatic wmem(input logic [6:0] i, input logic [3:0] v);
        xfer(1'b1, maddr(i), {28'h0000000, v});
        mdl[i] = v;
    endtask : wmem

    // reference behaviour of one executed instruction
    task automatic model_exec(input logic [15:0] ins);
        logic [6:0] ma;
        logic [6:0] ra;
        logic [3:0] n;
        logic [3:0] m;
        logic [4:0] d;
        logic cmpop;
        ma = ins[10:4];
        ra = {grow_m, ins[3:0]};
        n = ins[3:0];
        m = mdl[ma];
        d = {1'b0, m} - {1'b0, n};
        sk = 1'b0;
        cmpop = 1'b1;
        case (ins[15:11])
            nibble_unit_pkg::OP_EQUAL: sk = (d[3:0] == 4'h0);
            nibble_unit_pkg::OP_NOT_EQUAL: sk = (d[3:0] != 4'h0);
            nibble_unit_pkg::OP_GREATER_EQUAL: sk = !d[4];
            nibble_unit_pkg::OP_LESS: sk = d[4];
            default: cmpop = 1'b0;
        endcase
        if (cmpop) begin
            zf = (d[3:0] != 4'h0) ? 1'b0 : (cf ? zf : 1'b1);
        end
        case (ins[15:11])
            nibble_unit_pkg::OP_XOR_RM: mdl[ra] = mdl[ra] ^ m;
            nibble_unit_pkg::OP_XOR_MI: mdl[ma] = m ^ n;
            nibble_unit_pkg::OP_BITS_SET: begin
                cf = 1'b0;
                sk = ((m & n) == n);
            end
            nibble_unit_pkg::OP_BITS_CLEAR: begin
                cf = 1'b0;
                sk = ((m & n) == 4'h0);
            end
            nibble_unit_pkg::OP_ROTATE: begin
                if (ins[10:4] == nibble_unit_pkg::ROTATE_MID) begin
                    {mdl[ra], cy} = {cy, mdl[ra]};
                end
            end
            nibble_unit_pkg::OP_LOAD: mdl[ra] = m;
            default: ;
        endcase
    endtask : model_exec

    // watcher: every completed read is matched against the oldest note
    always @(negedge pclk) begin
        if (done === 1'b1 && req_write === 1'b0) begin
            if (exp_q.size() == 0) begin
                errors++;
            end else begin
                check(result, exp_q.pop_front());
            end
        end
    end

    initial begin
        logic [4:0] ops[10];
        logic [31:0] r;
        logic [15:0] ins;
        logic [6:0] ra;
        int k;
        ops = '{nibble_unit_pkg::OP_XOR_RM, nibble_unit_pkg::OP_XOR_MI,
            nibble_unit_pkg::OP_BITS_SET, nibble_unit_pkg::OP_BITS_CLEAR,
            nibble_unit_pkg::OP_EQUAL, nibble_unit_pkg::OP_NOT_EQUAL,
            nibble_unit_pkg::OP_GREATER_EQUAL, nibble_unit_pkg::OP_LESS,
            nibble_unit_pkg::OP_ROTATE, nibble_unit_pkg::OP_LOAD};
        seed = 32'hC334;
        presetn = 1'b0;
        req = 1'b0;
        req_write = 1'b0;
        req_addr = 12'h000;
        req_wdata = 32'h0000_0000;
        {cy, zf, cf, sk} = 4'h0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(nibble_unit_pkg::ADDR_INSTR, 33'h0_0000_0000);
        rd(nibble_unit_pkg::ADDR_STATUS, 33'h0_0000_0000);
        rd(nibble_unit_pkg::ADDR_GREG_ROW, 33'h0_0000_0000);
        rd(12'h00C, 33'h1_0000_0000);
        for (k = 0; k < 80; k++) begin
            r = $random(seed);
            grow_m = r[2:0];
            ins = {ops[k % 10], r[26:16]};
            // a rotate without its fixed middle bits must behave as a no-op
            if (ops[k % 10] == nibble_unit_pkg::OP_ROTATE && r[9]) begin
                ins[10:4] = nibble_unit_pkg::ROTATE_MID;
            end
            // half the time the operand equals memory, so equal compares hit
            if (r[8]) begin
                ins[3:0] = r[3:0];
            end
            ra = {grow_m, ins[3:0]};
            xfer(1'b1, nibble_unit_pkg::ADDR_GREG_ROW, {29'h0, grow_m});
            rd(nibble_unit_pkg::ADDR_GREG_ROW, {30'h0, grow_m});
            wmem(ra, r[7:4]);
            wmem(ins[10:4], r[3:0]);
            xfer(1'b1, nibble_unit_pkg::ADDR_STATUS, {28'h0, r[15:12]});
            {cf, zf, cy} = r[15:13];
            rd(nibble_unit_pkg::ADDR_STATUS, {29'h0, cf, zf, cy, sk});
            xfer(1'b1, nibble_unit_pkg::ADDR_INSTR, {16'h0000, ins});
            model_exec(ins);
            @(posedge pclk);
            @(negedge pclk);
            check({32'h0, skip_next}, {32'h0, sk});
            rd(nibble_unit_pkg::ADDR_STATUS, {29'h0, cf, zf, cy, sk});
            rd(maddr(ins[10:4]), {29'h0, mdl[ins[10:4]]});
            rd(maddr(ra), {29'h0, mdl[ra]});
            rd(nibble_unit_pkg::ADDR_INSTR, {17'h0, ins});
        end
        repeat (4) @(negedge pclk);
        if (exp_q.size() != 0) begin
            errors++;
        end
        test_done();
    end
endmodule : nibble_logic_skip_rotate_unit_bench

//--- dv/seq_apb_model.sv
// sequencer-side model: carries the bench's register transfers onto apb
`timescale 1ns/1ps
module seq_apb_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // bench requests
    input wire logic req,
    input wire logic req_write,
    input wire logic [11:0] req_addr,
    input wire logic [31:0] req_wdata,
    output logic done,
    output logic [32:0] result,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [31:0] prdata,
    input wire logic pslverr
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psel <= 1'b0;
            penable <= 1'b0;
            pwrite <= 1'b0;
            paddr <= 12'h000;
            pwdata <= 32'h0000_0000;
            done <= 1'b0;
            result <= 33'h0_0000_0000;
        end else begin
            done <= 1'b0;
            if (psel && penable && pready) begin
                // released lines flip so a stale address or data cannot pass
                psel <= 1'b0;
                penable <= 1'b0;
                paddr <= ~paddr;
                pwdata <= ~pwdata;
                done <= 1'b1;
                result <= {pslverr, prdata};
            end else if (psel) begin
                penable <= 1'b1;
            end else if (req && !done) begin
                psel <= 1'b1;
                pwrite <= req_write;
                paddr <= req_addr;
                pwdata <= req_wdata;
            end
        end
    end
endmodule : seq_apb_model

//--- hdl/nibble_alu.sv
// combinational nibble datapath: xor, bit tests, compares, rotate, load
`timescale 1ns/1ps
module nibble_alu (
    // decoded operands
    input wire logic [4:0] opcode,
    input wire logic [3:0] mem_val,
    input wire logic [3:0] greg_val,
    input wire logic [3:0] imm,
    // flags in
    input wire logic carry_in,
    input wire logic zero_in,
    input wire logic compare_in,
    // results
    output logic greg_we,
    output logic [3:0] greg_res,
    output logic mem_we,
    output logic [3:0] mem_res,
    output logic skip,
    output logic carry_we,
    output logic carry_res,
    output logic zero_res,
    output logic compare_res
);
    logic [4:0] diff;
    logic [3:0] masked;
    logic zero_after_sub;

    always_comb begin
        diff = {1'b0, mem_val} - {1'b0, imm};
        masked = mem_val & imm;
        // with compare set, a zero difference keeps the chained result
        if (diff[3:0] != 4'h0) begin
            zero_after_sub = 1'b0;
        end else if (compare_in) begin
            zero_after_sub = zero_in;
        end else begin
            zero_after_sub = 1'b1;
        end
        greg_we = 1'b0;
        greg_res = greg_val;
        mem_we = 1'b0;
        mem_res = mem_val;
        skip = 1'b0;
        carry_we = 1'b0;
        carry_res = carry_in;
        zero_res = zero_in;
        compare_res = compare_in;
        unique case (opcode)
            nibble_unit_pkg::OP_XOR_RM: begin
                greg_we = 1'b1;
                greg_res = greg_val ^ mem_val;
            end
            nibble_unit_pkg::OP_XOR_MI: begin
                mem_we = 1'b1;
                mem_res = mem_val ^ imm;
            end
            nibble_unit_pkg::OP_BITS_SET: begin
                compare_res = 1'b0;
                skip = (masked == imm);
            end
            nibble_unit_pkg::OP_BITS_CLEAR: begin
                compare_res = 1'b0;
                skip = (masked == 4'h0);
            end
            nibble_unit_pkg::OP_EQUAL: begin
                skip = (diff[3:0] == 4'h0);
                zero_res = zero_after_sub;
            end
            nibble_unit_pkg::OP_NOT_EQUAL: begin
                skip = (diff[3:0] != 4'h0);
                zero_res = zero_after_sub;
            end
            nibble_unit_pkg::OP_GREATER_EQUAL: begin
                skip = ~diff[4];
                zero_res = zero_after_sub;
            end
            nibble_unit_pkg::OP_LESS: begin
                skip = diff[4];
                zero_res = zero_after_sub;
            end
            nibble_unit_pkg::OP_ROTATE: begin
                greg_we = 1'b1;
                greg_res = {carry_in, greg_val[3:1]};
                carry_we = 1'b1;
                carry_res = greg_val[0];
            end
            nibble_unit_pkg::OP_LOAD: begin
                greg_we = 1'b1;
                greg_res = mem_val;
            end
            default: begin
                skip = 1'b0;
            end
        endcase
    end
endmodule : nibble_alu

//--- hdl/nibble_exec_unit.sv
// apb-controlled execution unit for the nibble xor, skip, rotate and load ops
//
// Functional notes
// - xor register with memory into register
// - xor memory with immediate into memory
// - bits-set test clears compare, skips on match
// - bits-clear test clears compare, skips on zero
// - equal compare skips when difference zero
// - not-equal compare skips when difference nonzero
// - greater-or-equal compare skips without borrow
// - less compare skips on borrow
// - rotate register right through carry
// - load copies memory nibble into register
// - zero flag follows compare-chained subtraction
`timescale 1ns/1ps
module nibble_exec_unit (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // sequencer side
    output logic skip_next
);
    typedef enum logic {ST_IDLE, ST_EXEC} exec_state_t;

    exec_state_t state;
    logic [15:0] instr;
    logic [2:0] greg_row;
    logic carry_flag;
    logic zero_flag;
    logic compare_flag;
    logic [3:0] mem [nibble_unit_pkg::MEM_WORDS];

    logic [4:0] opcode;
    logic [2:0] memory_row_field;
    logic [3:0] memory_column_field;
    logic [3:0] immediate_nibble;
    logic [6:0] mem_addr;
    logic [6:0] greg_addr;
    logic [3:0] mem_val;
    logic [3:0] greg_val;
    logic [4:0] exec_op;
    logic exec;
    logic access;
    logic wr_fire;
    nibble_unit_pkg::addr_kind_t kind;

    logic greg_we;
    logic [3:0] greg_res;
    logic mem_we;
    logic [3:0] mem_res;
    logic skip;
    logic carry_we;
    logic carry_res;
    logic zero_res;
    logic compare_res;
    logic greg_lsb;
    logic mem_ne_imm;

    function automatic nibble_unit_pkg::addr_kind_t decode_addr(input logic [11:0] a);
        if (a == nibble_unit_pkg::ADDR_INSTR) begin
            decode_addr = nibble_unit_pkg::AK_INSTR;
        end else if (a == nibble_unit_pkg::ADDR_STATUS) begin
            decode_addr = nibble_unit_pkg::AK_STATUS;
        end else if (a == nibble_unit_pkg::ADDR_GREG_ROW) begin
            decode_addr = nibble_unit_pkg::AK_GROW;
        end else if (a[nibble_unit_pkg::WIN_HI:nibble_unit_pkg::WIN_LO]
                     == nibble_unit_pkg::MEM_WINDOW && a[1:0] == 2'h0) begin
            decode_addr = nibble_unit_pkg::AK_MEM;
        end else begin
            decode_addr = nibble_unit_pkg::AK_NONE;
        end
    endfunction : decode_addr

    function automatic logic is_compare(input logic [4:0] op);
        is_compare = (op == nibble_unit_pkg::OP_EQUAL) || (op == nibble_unit_pkg::OP_NOT_EQUAL)
            || (op == nibble_unit_pkg::OP_GREATER_EQUAL) || (op == nibble_unit_pkg::OP_LESS);
    endfunction : is_compare

    // instruction fields
    assign opcode = instr[nibble_unit_pkg::OP_HI:nibble_unit_pkg::OP_LO];
    assign memory_row_field = instr[nibble_unit_pkg::ROW_HI:nibble_unit_pkg::ROW_LO];
    assign memory_column_field = instr[nibble_unit_pkg::COL_HI:nibble_unit_pkg::COL_LO];
    assign immediate_nibble = instr[nibble_unit_pkg::NIB_HI:nibble_unit_pkg::NIB_LO];
    assign mem_addr = {memory_row_field, memory_column_field};
    // the register operand is the column named by the nibble field, in the register row
    assign greg_addr = {greg_row, immediate_nibble};
    assign mem_val = mem[mem_addr];
    assign greg_val = mem[greg_addr];
    assign greg_lsb = greg_val[0];
    assign mem_ne_imm = (mem_val != immediate_nibble);
    assign exec = (state == ST_EXEC);

    // rotate only exists with its fixed middle bits; anything else there is a no-op
    always_comb begin
        exec_op = opcode;
        if (opcode == nibble_unit_pkg::OP_ROTATE
            && instr[nibble_unit_pkg::ROW_HI:nibble_unit_pkg::COL_LO]
               != nibble_unit_pkg::ROTATE_MID) begin
            exec_op = 5'h00;
        end
    end

    nibble_alu u_alu (
        .opcode(exec_op),
        .mem_val(mem_val),
        .greg_val(greg_val),
        .imm(immediate_nibble),
        .carry_in(carry_flag),
        .zero_in(zero_flag),
        .compare_in(compare_flag),
        .greg_we(greg_we),
        .greg_res(greg_res),
        .mem_we(mem_we),
        .mem_res(mem_res),
        .skip(skip),
        .carry_we(carry_we),
        .carry_res(carry_res),
        .zero_res(zero_res),
        .compare_res(compare_res)
    );

    // apb: one wait state so read data can come from a flop
    assign access = psel & penable;
    assign wr_fire = access & pready & pwrite;
    assign kind = decode_addr(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= access & ~pready;
            pslverr <= access & ~pready & (kind == nibble_unit_pkg::AK_NONE);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (access & ~pready & ~pwrite) begin
            unique case (kind)
                nibble_unit_pkg::AK_INSTR: prdata <= {16'h0000, instr};
                nibble_unit_pkg::AK_STATUS: begin
                    prdata <= {28'h0000000, compare_flag, zero_flag, carry_flag, skip_next};
                end
                nibble_unit_pkg::AK_GROW: prdata <= {29'h00000000, greg_row};
                nibble_unit_pkg::AK_MEM: begin
                    prdata <= {28'h0000000,
                        mem[paddr[nibble_unit_pkg::MIDX_HI:nibble_unit_pkg::MIDX_LO]]};
                end
                nibble_unit_pkg::AK_NONE: prdata <= 32'h00000000;
            endcase
        end
    end

    // writing the instruction register launches one execution cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr <= nibble_unit_pkg::INSTR_RESET;
            state <= ST_IDLE;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    if (wr_fire && kind == nibble_unit_pkg::AK_INSTR) begin
                        instr <= pwdata[15:0];
                        state <= ST_EXEC;
                    end
                end
                ST_EXEC: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            greg_row <= nibble_unit_pkg::GREG_ROW_RESET;
        end else if (wr_fire && kind == nibble_unit_pkg::AK_GROW) begin
            greg_row <= pwdata[2:0];
        end
    end

    // execution wins over a software flag write in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_next <= nibble_unit_pkg::FLAG_RESET;
            carry_flag <= nibble_unit_pkg::FLAG_RESET;
            zero_flag <= nibble_unit_pkg::FLAG_RESET;
            compare_flag <= nibble_unit_pkg::FLAG_RESET;
        end else if (exec) begin
            skip_next <= skip;
            if (carry_we) begin
                carry_flag <= carry_res;
            end
            zero_flag <= zero_res;
            compare_flag <= compare_res;
        end else if (wr_fire && kind == nibble_unit_pkg::AK_STATUS) begin
            carry_flag <= pwdata[nibble_unit_pkg::ST_CARRY];
            zero_flag <= pwdata[nibble_unit_pkg::ST_ZERO];
            compare_flag <= pwdata[nibble_unit_pkg::ST_COMPARE];
        end
    end

    // data memory holds no reset: software initialises it over the bus
    always_ff @(posedge pclk) begin
        if (exec && greg_we) begin
            mem[greg_addr] <= greg_res;
        end else if (exec && mem_we) begin
            mem[mem_addr] <= mem_res;
        end else if (wr_fire && kind == nibble_unit_pkg::AK_MEM) begin
            mem[paddr[nibble_unit_pkg::MIDX_HI:nibble_unit_pkg::MIDX_LO]] <= pwdata[3:0];
        end
    end

    a_xor_reg_result: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_XOR_RM)
        |=> mem[$past(greg_addr)] == ($past(greg_val) ^ $past(mem_val)))
        else $error("register xor result wrong");

    a_xor_mem_result: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_XOR_MI)
        |=> mem[$past(mem_addr)] == ($past(mem_val) ^ $past(immediate_nibble)))
        else $error("memory xor result wrong");

    a_bits_set_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_BITS_SET)
        |=> !compare_flag
            && skip_next == (($past(mem_val) & $past(immediate_nibble)) == $past(immediate_nibble)))
        else $error("bits-set skip wrong");

    a_bits_clear_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_BITS_CLEAR)
        |=> !compare_flag && skip_next == (($past(mem_val) & $past(immediate_nibble)) == 4'h0))
        else $error("bits-clear skip wrong");

    a_equal_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_EQUAL)
        |=> skip_next == !$past(mem_ne_imm))
        else $error("equal skip wrong");

    a_not_equal_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_NOT_EQUAL)
        |=> skip_next == $past(mem_ne_imm))
        else $error("not-equal skip wrong");

    a_greater_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_GREATER_EQUAL)
        |=> skip_next == ($past(mem_val) >= $past(immediate_nibble)))
        else $error("greater-or-equal skip wrong");

    a_less_skip: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_LESS)
        |=> skip_next == ($past(mem_val) < $past(immediate_nibble)))
        else $error("less skip wrong");

    a_rotate_carry: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_ROTATE)
        |=> carry_flag == $past(greg_lsb)
            && mem[$past(greg_addr)] == {$past(carry_flag), $past(greg_val[3:1])})
        else $error("rotate through carry wrong");

    a_rotate_fixed_bits: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && opcode == nibble_unit_pkg::OP_ROTATE && exec_op != nibble_unit_pkg::OP_ROTATE)
        |=> carry_flag == $past(carry_flag) && mem[$past(greg_addr)] == $past(greg_val))
        else $error("malformed rotate changed state");

    a_load_copy: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_LOAD)
        |=> mem[$past(greg_addr)] == $past(mem_val) && mem[$past(mem_addr)] == $past(mem_val))
        else $error("load copy wrong");

    a_zero_chain: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && is_compare(exec_op))
        |=> zero_flag == ($past(mem_ne_imm) ? 1'b0
            : ($past(compare_flag) ? $past(zero_flag) : 1'b1)))
        else $error("zero flag chaining wrong");

    a_compare_no_write: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && is_compare(exec_op)) |=> mem[$past(mem_addr)] == $past(mem_val))
        else $error("compare wrote memory");

    a_compare_keeps_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && is_compare(exec_op))
        |=> carry_flag == $past(carry_flag) && compare_flag == $past(compare_flag))
        else $error("compare changed carry or compare flag");

    a_bits_keep_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && (exec_op == nibble_unit_pkg::OP_BITS_SET
            || exec_op == nibble_unit_pkg::OP_BITS_CLEAR))
        |=> carry_flag == $past(carry_flag) && zero_flag == $past(zero_flag))
        else $error("bit test changed carry or zero");

    a_load_keeps_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (exec && exec_op == nibble_unit_pkg::OP_LOAD)
        |=> carry_flag == $past(carry_flag) && zero_flag == $past(zero_flag)
            && compare_flag == $past(compare_flag))
        else $error("load changed a flag");
endmodule : nibble_exec_unit

//--- hdl/nibble_unit_pkg.sv
// shared constants for the nibble logic, skip and rotate unit
package nibble_unit_pkg;
    // instruction fields
    localparam int INSTR_W = 16;
    localparam int OP_HI = 15;
    localparam int OP_LO = 11;
    localparam int ROW_HI = 10;
    localparam int ROW_LO = 8;
    localparam int COL_HI = 7;
    localparam int COL_LO = 4;
    localparam int NIB_HI = 3;
    localparam int NIB_LO = 0;
    localparam int NIB_W = 4;
    localparam int ROW_W = 3;
    localparam int COL_W = 4;
    localparam int MADDR_W = ROW_W + COL_W;
    localparam int MEM_WORDS = 1 << MADDR_W;

    // operation codes
    localparam logic [4:0] OP_XOR_RM = 5'h05;
    localparam logic [4:0] OP_XOR_MI = 5'h15;
    localparam logic [4:0] OP_BITS_SET = 5'h1E;
    localparam logic [4:0] OP_BITS_CLEAR = 5'h1F;
    localparam logic [4:0] OP_EQUAL = 5'h09;
    localparam logic [4:0] OP_NOT_EQUAL = 5'h0B;
    localparam logic [4:0] OP_GREATER_EQUAL = 5'h19;
    localparam logic [4:0] OP_LESS = 5'h1B;
    localparam logic [4:0] OP_ROTATE = 5'h07;
    localparam logic [6:0] ROTATE_MID = 7'h07;
    localparam logic [4:0] OP_LOAD = 5'h08;

    // apb map
    localparam int PADDR_W = 12;
    localparam logic [11:0] ADDR_INSTR = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_GREG_ROW = 12'h008;
    localparam logic [2:0] MEM_WINDOW = 3'h1;
    localparam int WIN_HI = 11;
    localparam int WIN_LO = 9;
    localparam int MIDX_HI = 8;
    localparam int MIDX_LO = 2;

    // status layout
    localparam int ST_SKIP = 0;
    localparam int ST_CARRY = 1;
    localparam int ST_ZERO = 2;
    localparam int ST_COMPARE = 3;

    // reset values
    localparam logic [15:0] INSTR_RESET = 16'h0000;
    localparam logic [2:0] GREG_ROW_RESET = 3'h0;
    localparam logic FLAG_RESET = 1'b0;

    typedef enum logic [2:0] {AK_INSTR, AK_STATUS, AK_GROW, AK_MEM, AK_NONE} addr_kind_t;
endpackage : nibble_unit_pkg
